// File: hdl/irsm_master_end.sv
// irsm_master_end: 8-bit serial port master with its register file.
// assumes: software on a plain register port (address, write data,
// write strobe, read strobe, read data one cycle later); the radio on
// the link keeps mode 0 and the same clock.
//
// How it works
// - four registers: control, data, configuration, rate
// - configuration register at 0x84, page 0
// - configuration bit 7 shows transfer busy
// - configuration bit 6 enables master operation
// - bit 5 centres data on first/second edge
// - bit 4 sets serial clock idle level
// - configuration bits 3:0 read zero, writes ignored
// - miso sampled one clock before bit end
// - control register at 0xb0, page 0
// - transfer end sets complete flag
// - set flags raise the interrupt request
// - flags cleared only by software writes
// - data write while busy sets collision
// - mode fault on select low, master, mode 01
// - software writes zero to control bit 4
// - software keeps slave-select mode at 00
// - accepted data write clears transmit-buffer-empty
// - move to shifter sets transmit-buffer-empty
// - data write loads buffer, starts when idle
// - msb first; full byte to receive buffer
// - serial clock is clock / (2*(rate+1))
// - colliding write discarded, buffer unchanged
`timescale 1ns/1ps
module irsm_master_end
  import irsm_pkg::*;
(
  input  wire logic       clock_i,    // system clock, 100 MHz
  input  wire logic       srst_i,     // synchronous reset, high
  input  wire logic [7:0] addr_i,     // register address
  input  wire logic [7:0] wdata_i,    // write data
  input  wire logic       wr_i,       // write strobe
  input  wire logic       rd_i,       // read strobe
  output logic      [7:0] rdata_o,    // read data, cycle after rd_i
  input  wire logic       select_n_i, // radio select level from user
  output logic            irq_o,      // interrupt request level
  irsm_link_if.master     link        // serial link
);
  import irsm_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // register state
  logic       master_operation_enable_ff;  // master enable
  logic       clock_phase_select_ff;  // clock phase
  logic       clock_idle_polarity_ff;  // clock idle level
  logic       done_ff;   // transfer complete flag
  logic       wcol_ff;   // write collision flag
  logic       modf_ff;   // mode fault flag
  logic       rsv_ff;    // reserved control bit, as written
  logic [1:0] ssm_ff;    // slave-select mode
  logic       txbmt_ff;  // transmit buffer empty
  logic       en_ff;     // port enable
  logic [7:0] rate_ff;   // clock divider value
  logic [7:0] txbuf_ff;  // transmit buffer
  logic [7:0] rxbuf_ff;  // receive buffer
  logic [7:0] rdata_ff;  // read answer

  // shift engine state
  logic       busy_ff;   // transfer running
  logic [7:0] cnt_ff;    // half-bit divider count
  logic       half_ff;   // 0 first half of bit, 1 second
  logic [2:0] bit_ff;    // bit index in byte
  logic [7:0] shift_ff;  // shift register
  logic       sck_ff;    // serial clock pin
  logic       mosi_ff;   // data out pin

  // next values of the engine
  logic       nxt_busy;
  logic [7:0] nxt_cnt;
  logic       nxt_half;
  logic [2:0] nxt_bit;
  logic [7:0] nxt_shift;
  logic       start;     // buffer moves to shifter
  logic       finish;    // last bit sampled
  logic       run_ok;    // port may transfer

  // decoded software strobes
  logic       wr_cfg;
  logic       wr_ctl;
  logic       wr_rate;
  logic       wr_data;
  logic       collide;   // data write refused
  logic       fault;     // mode fault condition

  assign wr_cfg  = wr_i && addr_i == IRSM_ADDR_CFG;
  assign wr_ctl  = wr_i && addr_i == IRSM_ADDR_CTRL;
  assign wr_rate = wr_i && addr_i == IRSM_ADDR_RATE;
  assign wr_data = wr_i && addr_i == IRSM_ADDR_DATA && en_ff;
  assign run_ok  = en_ff && master_operation_enable_ff;

  // busy or buffer still full refuses the byte
  assign collide = wr_data && (busy_ff || !txbmt_ff);
  // master collision with select pulled low
  assign fault   = !select_n_i && master_operation_enable_ff && ssm_ff == IRSM_SSM_FAULT;

  ////////////////////////////////////////////////////////////////////////
  // configuration register
  // software sets master enable
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      master_operation_enable_ff <= 1'b0;
      clock_phase_select_ff <= 1'b0;
      clock_idle_polarity_ff <= 1'b0;
    end
    else if (wr_cfg)
    begin
      master_operation_enable_ff <= wdata_i[IRSM_CFG_MASTER_OPERATION_ENABLE];
      clock_phase_select_ff <= wdata_i[IRSM_CFG_CLOCK_PHASE_SELECT];
      clock_idle_polarity_ff <= wdata_i[IRSM_CFG_CLOCK_IDLE_POLARITY];
    end
  end

  // plain control fields and rate
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      rsv_ff  <= IRSM_CTRL_RST[IRSM_CTL_RSV];
      ssm_ff  <= IRSM_CTRL_RST[IRSM_CTL_SSM_H:IRSM_CTL_SSM_L];
      en_ff   <= IRSM_CTRL_RST[IRSM_CTL_EN];
      rate_ff <= IRSM_RATE_RST;
    end
    else
    begin
      // mode field kept as written, only 01 has an effect
      if (wr_ctl)
      begin
        rsv_ff <= wdata_i[IRSM_CTL_RSV];
        ssm_ff <= wdata_i[IRSM_CTL_SSM_H:IRSM_CTL_SSM_L];
        en_ff  <= wdata_i[IRSM_CTL_EN];
      end
      if (wr_rate)
        rate_ff <= wdata_i;
    end
  end

  // sticky flags: a hardware set beats a software clear in the same cycle
  // only a control write clears a flag
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      done_ff <= IRSM_CTRL_RST[IRSM_CTL_DONE];
      wcol_ff <= IRSM_CTRL_RST[IRSM_CTL_WCOL];
      modf_ff <= IRSM_CTRL_RST[IRSM_CTL_MODF];
    end
    else
    begin
      done_ff <= finish  | (wr_ctl ? wdata_i[IRSM_CTL_DONE] : done_ff);
      wcol_ff <= collide | (wr_ctl ? wdata_i[IRSM_CTL_WCOL] : wcol_ff);
      modf_ff <= fault   | (wr_ctl ? wdata_i[IRSM_CTL_MODF] : modf_ff);
    end
  end

  // any set flag requests service; the cpu gates it
  assign irq_o = done_ff | wcol_ff | modf_ff;

  // transmit buffer and its empty flag
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      txbuf_ff <= IRSM_DATA_RST;
      txbmt_ff <= IRSM_CTRL_RST[IRSM_CTL_TXBMT];
    end
    else if (wr_data && !collide)
    begin
      // accepted byte waits in the buffer
      txbuf_ff <= wdata_i;
      txbmt_ff <= 1'b0;
    end
    else if (start)
      txbmt_ff <= 1'b1;
    // a refused write leaves the buffer alone
  end

  ////////////////////////////////////////////////////////////////////////
  // shift engine, computed as next values so pins come from flops
  // start as soon as the shifter is free
  assign start = !busy_ff && !txbmt_ff && run_ok;

  always_comb
  begin
    nxt_busy  = busy_ff;
    nxt_cnt   = cnt_ff;
    nxt_half  = half_ff;
    nxt_bit   = bit_ff;
    nxt_shift = shift_ff;
    finish    = 1'b0;
    if (!run_ok)
    begin
      // disabling aborts and parks the clock
      nxt_busy = 1'b0;
      nxt_cnt  = 8'h00;
      nxt_half = 1'b0;
    end
    else if (start)
    begin
      nxt_busy  = 1'b1;
      nxt_cnt   = 8'h00;
      nxt_half  = 1'b0;
      nxt_bit   = 3'h0;
      nxt_shift = txbuf_ff;
    end
    else if (busy_ff)
    begin
      if (cnt_ff == rate_ff)
      begin
        nxt_cnt  = 8'h00;
        nxt_half = !half_ff;
        if (half_ff)
        begin
          // last clock of the bit takes miso
          nxt_shift = {shift_ff[6:0], link.miso};
          nxt_bit   = bit_ff + 3'h1;
          if (bit_ff == IRSM_LAST_BIT)
          begin
            nxt_busy = 1'b0;
            finish   = 1'b1;
          end
        end
      end
      else
        nxt_cnt = cnt_ff + 8'h01;
    end
  end

  // engine registers
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      busy_ff  <= 1'b0;
      cnt_ff   <= 8'h00;
      half_ff  <= 1'b0;
      bit_ff   <= 3'h0;
      shift_ff <= IRSM_DATA_RST;
    end
    else
    begin
      busy_ff  <= nxt_busy;
      cnt_ff   <= nxt_cnt;
      half_ff  <= nxt_half;
      bit_ff   <= nxt_bit;
      shift_ff <= nxt_shift;
    end
  end

  // pin flops: loaded from the next values, so they change with the engine, aligned with each other
  // idle level follows polarity
  // phase picks the active half of the bit
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      sck_ff  <= 1'b0;
      mosi_ff <= 1'b0;
    end
    else
    begin
      sck_ff  <= clock_idle_polarity_ff ^ (nxt_busy & (clock_phase_select_ff ? !nxt_half : nxt_half));
      mosi_ff <= nxt_shift[7];
    end
  end

  assign link.sck   = sck_ff;
  assign link.mosi  = mosi_ff;
  assign link.sel_n = select_n_i;

  // completed byte to the receive buffer
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      rxbuf_ff <= IRSM_DATA_RST;
    else if (finish)
      rxbuf_ff <= {shift_ff[6:0], link.miso};
  end

  ////////////////////////////////////////////////////////////////////////
  // read port, answer one cycle after the strobe
  // four readable registers
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      rdata_ff <= 8'h00;
    else if (rd_i)
    begin
      case (addr_i)
        IRSM_ADDR_CFG:  rdata_ff <= {busy_ff, master_operation_enable_ff, clock_phase_select_ff,
                                     clock_idle_polarity_ff, 4'h0};
        IRSM_ADDR_CTRL: rdata_ff <= {done_ff, wcol_ff, modf_ff, rsv_ff,
                                     ssm_ff, txbmt_ff, en_ff};
        IRSM_ADDR_RATE: rdata_ff <= rate_ff;
        IRSM_ADDR_DATA: rdata_ff <= rxbuf_ff;
        default:        rdata_ff <= 8'h00; // unmapped reads zero
      endcase
    end
    else
      rdata_ff <= 8'h00;
  end

  assign rdata_o = rdata_ff;
endmodule

// File: hdl/irsm_pkg.sv
// irsm_pkg: shared constants of the on-chip radio serial port.
// assumes: both link ends and the register port import this package.
package irsm_pkg;

  // register addresses on the device register port (special-register map)
  localparam logic [7:0] IRSM_ADDR_CFG  = 8'h84; // serial_port_configuration
  localparam logic [7:0] IRSM_ADDR_RATE = 8'h85; // serial_clock_rate
  localparam logic [7:0] IRSM_ADDR_DATA = 8'h86; // serial_port_data
  localparam logic [7:0] IRSM_ADDR_CTRL = 8'hb0; // serial_port_control
  localparam logic [3:0] IRSM_REG_PAGE  = 4'h0;  // page of all four

  // configuration field positions
  localparam int IRSM_CFG_BUSY  = 7; // transfer_in_progress
  localparam int IRSM_CFG_MASTER_OPERATION_ENABLE = 6; // master_operation_enable
  localparam int IRSM_CFG_CLOCK_PHASE_SELECT = 5; // clock_phase_select
  localparam int IRSM_CFG_CLOCK_IDLE_POLARITY = 4; // clock_idle_polarity

  // control field positions
  localparam int IRSM_CTL_DONE  = 7; // transfer_complete_flag
  localparam int IRSM_CTL_WCOL  = 6; // write_collision_flag
  localparam int IRSM_CTL_MODF  = 5; // mode_fault_flag
  localparam int IRSM_CTL_RSV   = 4; // reserved, stored as written
  localparam int IRSM_CTL_SSM_H = 3; // slave_select_mode msb
  localparam int IRSM_CTL_SSM_L = 2; // slave_select_mode lsb
  localparam int IRSM_CTL_TXBMT = 1; // transmit_buffer_empty
  localparam int IRSM_CTL_EN    = 0; // port_enable

  // reset values
  localparam logic [7:0] IRSM_CTRL_RST = 8'h06;
  localparam logic [7:0] IRSM_RATE_RST = 8'h00;
  localparam logic [7:0] IRSM_DATA_RST = 8'h00;

  // slave-select mode that arms the mode-fault detector
  localparam logic [1:0] IRSM_SSM_FAULT = 2'h1;

  // bits in a byte, last bit index
  localparam logic [2:0] IRSM_LAST_BIT = 3'h7;

endpackage

// File: hdl/irsm_link_if.sv
// irsm_link_if: the serial link between port master and radio slave.
// assumes: one system clock; the master makes the serial clock itself.
`timescale 1ns/1ps
interface irsm_link_if;
  logic sck;   // serial clock, made by the master
  logic mosi;  // master to radio data
  logic miso;  // radio to master data
  logic sel_n; // radio select, active low

  modport master
  (
    output sck,
    output mosi,
    output sel_n,
    input  miso
  );

  modport radio
  (
    input  sck,
    input  mosi,
    input  sel_n,
    output miso
  );
endinterface

// File: hdl/irsm_radio_end.sv
// irsm_radio_end: radio side of the link, a mode-0 byte shifter.
// assumes: same clock as the master; divider value of 1 or more so that
// every serial clock level lasts at least two system clocks.
`timescale 1ns/1ps
module irsm_radio_end
  import irsm_pkg::*;
(
  input  wire logic       clock_i,   // system clock
  input  wire logic       srst_i,    // synchronous reset, high
  irsm_link_if.radio      link,      // serial link
  input  wire logic [7:0] tx_data_i, // byte to return next
  output logic      [7:0] rx_data_o, // last byte received
  output logic            rx_valid_o // one-cycle pulse per byte
);
  import irsm_pkg::*;

  logic       sck_q_ff;   // serial clock one cycle ago
  logic [2:0] bit_ff;     // bits taken in this byte
  logic [7:0] rx_sh_ff;   // incoming shifter
  logic [7:0] tx_sh_ff;   // outgoing shifter
  logic [7:0] rx_data_ff; // captured byte
  logic       rx_vld_ff;  // capture pulse
  logic       rise;       // sampling edge
  logic       fall;       // shifting edge

  // same clock as the master, so no synchroniser is needed
  assign rise = ~link.sel_n & link.sck & ~sck_q_ff;
  assign fall = ~link.sel_n & ~link.sck & sck_q_ff;

  // deselected line floats to its pull-up level, as the real pin does
  assign link.miso  = link.sel_n | tx_sh_ff[7];
  assign rx_data_o  = rx_data_ff;
  assign rx_valid_o = rx_vld_ff;

  //////////////////////////////////////////////////////////////////////////
  // edge history
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      sck_q_ff <= 1'b0;
    else
      sck_q_ff <= link.sck;
  end

  // sample on the rising edge, msb first
  always_ff @(posedge clock_i)
  begin
    if (srst_i || link.sel_n)
    begin
      bit_ff    <= 3'h0;
      rx_sh_ff  <= IRSM_DATA_RST;
      rx_vld_ff <= 1'b0;
    end
    else if (rise)
    begin
      bit_ff   <= bit_ff + 3'h1;
      rx_sh_ff <= {rx_sh_ff[6:0], link.mosi};
      // whole byte seen
      rx_vld_ff <= (bit_ff == IRSM_LAST_BIT);
    end
    else
      rx_vld_ff <= 1'b0;
  end

  // received byte register
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      rx_data_ff <= IRSM_DATA_RST;
    else if (rise && bit_ff == IRSM_LAST_BIT)
      rx_data_ff <= {rx_sh_ff[6:0], link.mosi};
  end

  // drive out on the falling edge, reload at byte boundary
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      tx_sh_ff <= IRSM_DATA_RST;
    else if (link.sel_n || (fall && bit_ff == 3'h0))
      tx_sh_ff <= tx_data_i;
    else if (fall)
      tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
  end
endmodule

// File: testbench/irsm_chk.sv
// irsm_chk: link assertions for the radio serial port.
// assumes: divider value 1, so each serial clock level stands 2 clocks;
// the select line is high whenever the serial clock idles at level 1.
`timescale 1ns/1ps
module irsm_chk
(
  input wire logic clock_i, // system clock
  input wire logic srst_i,  // sync reset, high
  input wire logic sck,     // serial clock
  input wire logic mosi,    // master to radio
  input wire logic miso,    // radio to master
  input wire logic sel_n    // radio select, low
);
  logic [2:0] bits_ff; // rises seen in the current byte
  logic       sck_ff;  // serial clock one cycle back

  default clocking dc @(posedge clock_i);
  endclocking
  default disable iff (srst_i);

  ////////////////////////////////////////////////////////////////////
  // count selected rising edges, wraps at a whole byte
  always_ff @(posedge clock_i)
  begin
    sck_ff <= sck;
    if (srst_i)
      bits_ff <= 3'h0;
    else if (!sel_n && sck && !sck_ff)
      bits_ff <= bits_ff + 3'h1;
  end

  ////////////////////////////////////////////////////////////////////
  rst_idle_a: assert property ($fell(srst_i) |-> !sck && !mosi)
    else $error("serial clock or data not idle after reset");
  high_half_a: assert property
    (!sel_n && $rose(sck) |-> sck[*2] ##1 !sck)
    else $error("serial clock high half not two clocks");
  // mid-byte only: the gap between bytes may be longer
  low_half_a: assert property
    (!sel_n && $fell(sck) && bits_ff != 3'h0 |-> !sck[*2] ##1 sck)
    else $error("serial clock low half not two clocks");
  mosi_hold_a: assert property (!sel_n && sck |-> $stable(mosi))
    else $error("master data moved while clock high");
  setup_low_a: assert property
    (!sel_n && $rose(sck) |-> !$past(sck, 2))
    else $error("clock rose without data set up first");
  miso_hold_a: assert property (!sel_n && sck |-> $stable(miso))
    else $error("radio data moved while clock high");
endmodule

// File: testbench/test_internal_radio_spi_master.sv
// test_internal_radio_spi_master: both link ends joined back to back.
// assumes: mode 0 radio end, so the divider is kept at 1 in transfers.
`timescale 1ns/1ps
module test_internal_radio_spi_master;
  import irsm_pkg::*;
  logic       clock_i;     // system clock
  logic       srst_i;      // sync reset
  logic [7:0] addr;        // register address
  logic [7:0] wdata;       // write data
  logic       wr_s;        // write strobe
  logic       rd_s;        // read strobe
  logic [7:0] rdata;       // read data
  logic       sel_n;       // radio select, low
  logic       irq;         // interrupt request
  logic [7:0] tx_data;     // radio reply byte
  logic [7:0] rx_data;     // radio received byte
  logic       rx_valid;    // radio byte pulse
  logic [7:0] rxq[$];      // bytes seen by the radio
  int         mismatches;  // failed compares
  int         comparisons; // all compares
  int         rises;       // serial clock rising edges
  int         n;           // bounded wait count

  irsm_link_if irsm_link_if_i();
  irsm_master_end irsm_master_end_i(.clock_i(clock_i), .srst_i(srst_i),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s),
    .rdata_o(rdata), .select_n_i(sel_n), .irq_o(irq),
    .link(irsm_link_if_i));
  irsm_radio_end irsm_radio_end_i(.clock_i(clock_i), .srst_i(srst_i),
    .link(irsm_link_if_i), .tx_data_i(tx_data), .rx_data_o(rx_data),
    .rx_valid_o(rx_valid));
  irsm_chk irsm_chk_i(.clock_i(clock_i), .srst_i(srst_i),
    .sck(irsm_link_if_i.sck), .mosi(irsm_link_if_i.mosi),
    .miso(irsm_link_if_i.miso), .sel_n(irsm_link_if_i.sel_n));

  ////////////////////////////////////////////////////////////////////
  // clock, and watchers on the wire and the radio side
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge irsm_link_if_i.sck)
    if (!srst_i)
      rises++;
  always @(posedge clock_i)
    if (rx_valid === 1'b1)
      rxq.push_back(rx_data);

  ////////////////////////////////////////////////////////////////////
  task automatic check(input string w, input logic [7:0] s,
                       input logic [7:0] e);
    comparisons++;
    if (s !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", w, e, s);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clock_i);
    wr_s  <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input string w);
    @(posedge clock_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock_i);
    rd_s <= 1'b0;
    #1;
    check(w, rdata, e);
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clock_i);
  endtask
  // bounded wait for k bytes at the radio; a timeout is a mismatch
  task automatic wait_rx(input int k);
    n = 0;
    while (rxq.size() < k && n < 500)
    begin
      @(posedge clock_i);
      n++;
    end
    if (n == 500)
    begin
      mismatches++;
      finish_test;
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  initial
  begin
    srst_i  = 1'b1;
    addr    = 8'h00;
    wdata   = 8'h00;
    wr_s    = 1'b0;
    rd_s    = 1'b0;
    sel_n   = 1'b1;
    tx_data = 8'h3c;
    idle(8);
    srst_i <= 1'b0;
    rd(IRSM_ADDR_CFG, 8'h00, "cfg");
    rd(IRSM_ADDR_CTRL, 8'h06, "ctrl");
    rd(IRSM_ADDR_RATE, 8'h00, "rate");
    rd(IRSM_ADDR_DATA, 8'h00, "data");
    // unmapped write must touch nothing
    wr(8'h87, 8'hff);
    rd(IRSM_ADDR_CTRL, 8'h06, "ctrl");
    rd(IRSM_ADDR_RATE, 8'h00, "rate");
    wr(IRSM_ADDR_CFG, 8'h7f);
    rd(IRSM_ADDR_CFG, 8'h70, "cfg");
    // data write with the port off
    wr(IRSM_ADDR_CFG, 8'h40);
    // the 7f configuration write above already raised the clock once
    rises = 0;
    wr(IRSM_ADDR_DATA, 8'ha5);
    idle(20);
    check("rises", rises[7:0], 8'h00);
    rd(IRSM_ADDR_CTRL, 8'h06, "ctrl");
    wr(IRSM_ADDR_RATE, 8'h01);
    rd(IRSM_ADDR_RATE, 8'h01, "rate");
    wr(IRSM_ADDR_CTRL, 8'h01);
    rd(IRSM_ADDR_CTRL, 8'h03, "ctrl");
    // idle level follows the polarity bit
    wr(IRSM_ADDR_CFG, 8'h50);
    idle(3);
    check("sck", {7'h0, irsm_link_if_i.sck}, 8'h01);
    wr(IRSM_ADDR_CFG, 8'h40);
    idle(3);
    check("sck", {7'h0, irsm_link_if_i.sck}, 8'h00);
    rises = 0;
    sel_n <= 1'b0;
    // master off: an accepted byte waits in the buffer
    wr(IRSM_ADDR_CFG, 8'h00);
    wr(IRSM_ADDR_DATA, 8'h96);
    rd(IRSM_ADDR_CTRL, 8'h01, "ctrl");
    // buffer still full: refused and flagged
    wr(IRSM_ADDR_DATA, 8'h5a);
    rd(IRSM_ADDR_CTRL, 8'h41, "ctrl");
    check("irq", {7'h0, irq}, 8'h01);
    // master enable set before the exchange starts
    wr(IRSM_ADDR_CFG, 8'h40);
    idle(2);
    rd(IRSM_ADDR_CFG, 8'hc0, "busy");
    rd(IRSM_ADDR_CTRL, 8'h43, "ctrl");
    // reserved control bit always written zero
    wr(IRSM_ADDR_CTRL, 8'h01);
    // a write while the byte is on the wire collides too
    wr(IRSM_ADDR_DATA, 8'hff);
    rd(IRSM_ADDR_CTRL, 8'h43, "ctrl");
    wait_rx(1);
    wr(IRSM_ADDR_DATA, 8'h5a);
    wait_rx(2);
    idle(10);
    check("rx0", rxq[0], 8'h96);
    check("rx1", rxq[1], 8'h5a);
    check("rises", rises[7:0], 8'h10);
    rd(IRSM_ADDR_DATA, 8'h3c, "data");
    rd(IRSM_ADDR_CFG, 8'h40, "cfg");
    rd(IRSM_ADDR_CTRL, 8'hc3, "ctrl");
    check("irq", {7'h0, irq}, 8'h01);
    idle(20);
    rd(IRSM_ADDR_CTRL, 8'hc3, "ctrl");
    wr(IRSM_ADDR_CTRL, 8'h01);
    rd(IRSM_ADDR_CTRL, 8'h03, "ctrl");
    check("irq", {7'h0, irq}, 8'h00);
    // select low in fault-armed mode
    wr(IRSM_ADDR_CTRL, 8'h05);
    idle(2);
    rd(IRSM_ADDR_CTRL, 8'h27, "ctrl");
    check("irq", {7'h0, irq}, 8'h01);
    sel_n <= 1'b1;
    idle(2);
    wr(IRSM_ADDR_CTRL, 8'h01);
    rd(IRSM_ADDR_CTRL, 8'h03, "ctrl");
    // second clock phase, select high: clock rises in the first half
    wr(IRSM_ADDR_CFG, 8'h60);
    wr(IRSM_ADDR_DATA, 8'h81);
    idle(2);
    check("sck", {7'h0, irsm_link_if_i.sck}, 8'h01);
    idle(40);
    check("sck", {7'h0, irsm_link_if_i.sck}, 8'h00);
    rd(IRSM_ADDR_CTRL, 8'h83, "ctrl");
    // deselected radio line reads as all ones
    rd(IRSM_ADDR_DATA, 8'hff, "data");
    finish_test;
  end
endmodule
